//--- slxb_regs.vh
// Register map, field layout and reset constants of the upper lane crossbar.
`ifndef SLXB_REGS_VH
`define SLXB_REGS_VH

// Register indices; the byte address of each is four times its index.
`define SLXB_IDX_XBAR45        10'h30a
`define SLXB_IDX_XBAR67        10'h30b
`define SLXB_IDX_FULL_STATUS   10'h30c
`define SLXB_IDX_IRQ_STATUS    10'h320
`define SLXB_IDX_IRQ_MASK      10'h321

`define SLXB_ADDR_XBAR45       ({`SLXB_IDX_XBAR45, 2'b00})
`define SLXB_ADDR_XBAR67       ({`SLXB_IDX_XBAR67, 2'b00})
`define SLXB_ADDR_FULL_STATUS  ({`SLXB_IDX_FULL_STATUS, 2'b00})
`define SLXB_ADDR_IRQ_STATUS   ({`SLXB_IDX_IRQ_STATUS, 2'b00})
`define SLXB_ADDR_IRQ_MASK     ({`SLXB_IDX_IRQ_MASK, 2'b00})

// Field positions inside a crossbar register.
`define SLXB_SEL_HI_MSB        5
`define SLXB_SEL_HI_LSB        3
`define SLXB_SEL_LO_MSB        2
`define SLXB_SEL_LO_LSB        0
`define SLXB_XBAR_RW_MASK      8'h3f

// Reset values.
`define SLXB_RST_SEL_FOUR      3'h4
`define SLXB_RST_SEL_FIVE      3'h5
`define SLXB_RST_SEL_SIX       3'h6
`define SLXB_RST_SEL_SEVEN     3'h7
`define SLXB_RST_FULL_STATUS   8'h00
`define SLXB_RST_IRQ_STATUS    8'h00
`define SLXB_RST_IRQ_MASK      8'h00

`endif

//--- slxb_lane_mux.v
// Eight-to-one lane selector for one logical lane.
`timescale 1ns/1ps
`default_nettype none

module slxb_lane_mux (
   input  wire [7:0] physLanes,
   input  wire [2:0] sel,
   output wire       laneOut
);

   // Selector value n picks physical lane n, 000 through 111.
   assign laneOut = physLanes[sel];

endmodule // slxb_lane_mux

`default_nettype wire

//--- slxb_crossbar_upper.v
// Upper logical lane crossbar with APB register file and full-flag interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "slxb_regs.vh"

module slxb_crossbar_upper (
   input  wire        core_clk,
   input  wire        rstn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire [31:0] prdata,
   output wire        pslverr,
   // Physical serial inputs, one bit per lane.
   input  wire [7:0]  physical_serial_input,
   // Per physical lane buffer full flags from the lane buffers.
   input  wire [7:0]  laneFifoFull,
   // Logical lanes 4 to 7, bit 0 is logical lane 4.
   output wire [3:0]  logicalLaneOut,
   // Level interrupt.
   output wire        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   reg  [2:0]  logical_four_source_select_q;
   reg  [2:0]  logical_five_source_select_q;
   reg  [2:0]  logical_six_source_select_q;
   reg  [2:0]  logical_seven_source_select_q;
   reg  [7:0]  fullStatus_q;
   reg  [7:0]  fullPrev_q;
   reg  [7:0]  irqStatus_q;
   reg  [7:0]  irqStatus_d;
   reg  [7:0]  irqMask_q;
   reg  [3:0]  laneOut_q;
   reg         respValid_q;
   reg  [31:0] prdata_q;
   reg         pslverr_q;
   reg  [7:0]  readValue;
   reg         addrHit;

   wire [11:0] laneSel;
   wire [3:0]  laneMuxOut;
   wire [7:0]  fullRise;
   wire        accessPhase;
   wire        xferDone;
   wire        wrDone;
   wire        rdDone;
   wire        alignedOk;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode helper.

   // True when the byte address names the register with the given index.
   function hitIndex;
      input [11:0] addr;
      input [9:0]  idx;
      begin
         hitIndex = (addr == {idx, 2'b00});
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake.

   // One wait state: the first access cycle loads the read word into a flop,
   // the second completes. This keeps prdata registered at the cost of a cycle.
   assign accessPhase = psel & penable;
   assign pready      = accessPhase & respValid_q;
   assign xferDone    = accessPhase & respValid_q;
   assign wrDone      = xferDone & pwrite & ~pslverr_q;
   assign rdDone      = xferDone & ~pwrite & ~pslverr_q;
   assign prdata      = prdata_q;
   assign pslverr     = pready & pslverr_q;
   assign alignedOk   = (paddr[1:0] == 2'b00);

   always @* begin
      readValue = 8'h00;
      addrHit   = 1'b1;
      if (hitIndex(paddr, `SLXB_IDX_XBAR45)) begin
         // Reserved bits 7:6 read as zero.
         readValue = {2'b00, logical_five_source_select_q, logical_four_source_select_q};
      end else if (hitIndex(paddr, `SLXB_IDX_XBAR67)) begin
         readValue = {2'b00, logical_seven_source_select_q, logical_six_source_select_q};
      end else if (hitIndex(paddr, `SLXB_IDX_FULL_STATUS)) begin
         readValue = fullStatus_q;
      end else if (hitIndex(paddr, `SLXB_IDX_IRQ_STATUS)) begin
         readValue = irqStatus_q;
      end else if (hitIndex(paddr, `SLXB_IDX_IRQ_MASK)) begin
         readValue = irqMask_q;
      end else begin
         addrHit = 1'b0;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         respValid_q <= 1'b0;
         prdata_q    <= 32'h0000_0000;
         pslverr_q   <= 1'b0;
      end else if (xferDone) begin
         respValid_q <= 1'b0;
      end else if (accessPhase) begin
         respValid_q <= 1'b1;
         pslverr_q   <= ~(addrHit & alignedOk);
         if (!pwrite && addrHit && alignedOk) begin
            prdata_q <= {24'h00_0000, readValue};
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossbar selector registers.

   // Only bits 5:0 are stored, so writes to the reserved bits fall away.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         logical_four_source_select_q  <= `SLXB_RST_SEL_FOUR;
         logical_five_source_select_q  <= `SLXB_RST_SEL_FIVE;
         logical_six_source_select_q   <= `SLXB_RST_SEL_SIX;
         logical_seven_source_select_q <= `SLXB_RST_SEL_SEVEN;
      end else if (wrDone) begin
         if (hitIndex(paddr, `SLXB_IDX_XBAR45)) begin
            logical_five_source_select_q <= pwdata[`SLXB_SEL_HI_MSB:`SLXB_SEL_HI_LSB];
            logical_four_source_select_q <= pwdata[`SLXB_SEL_LO_MSB:`SLXB_SEL_LO_LSB];
         end
         if (hitIndex(paddr, `SLXB_IDX_XBAR67)) begin
            logical_seven_source_select_q <= pwdata[`SLXB_SEL_HI_MSB:`SLXB_SEL_HI_LSB];
            logical_six_source_select_q   <= pwdata[`SLXB_SEL_LO_MSB:`SLXB_SEL_LO_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lane routing.

   assign laneSel = {logical_seven_source_select_q, logical_six_source_select_q,
                     logical_five_source_select_q, logical_four_source_select_q};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gLane
         slxb_lane_mux uMux (
            .physLanes (physical_serial_input),
            .sel       (laneSel[3*gi+2:3*gi]),
            .laneOut   (laneMuxOut[gi])
         );
      end
   endgenerate

   // A selector change takes effect on the next edge; the lane may glitch one
   // bit across the change, so software should switch lanes while idle.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         laneOut_q <= 4'h0;
      end else begin
         laneOut_q <= laneMuxOut;
      end
   end

   assign logicalLaneOut = laneOut_q;

   ////////////////////////////////////////////////////////////////////////////
   // Full flag status and interrupt.

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fullStatus_q <= `SLXB_RST_FULL_STATUS;
         fullPrev_q   <= 8'h00;
      end else begin
         fullStatus_q <= laneFifoFull;
         fullPrev_q   <= fullStatus_q;
      end
   end

   // A lane buffer becoming full is the interrupt event.
   assign fullRise = fullStatus_q & ~fullPrev_q;

   // Read clears only the bits that were returned; a new event wins.
   always @* begin
      irqStatus_d = irqStatus_q;
      if (rdDone && hitIndex(paddr, `SLXB_IDX_IRQ_STATUS)) begin
         irqStatus_d = irqStatus_q & ~prdata_q[7:0];
      end
      irqStatus_d = irqStatus_d | fullRise;
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irqStatus_q <= `SLXB_RST_IRQ_STATUS;
         irqMask_q   <= `SLXB_RST_IRQ_MASK;
      end else begin
         irqStatus_q <= irqStatus_d;
         if (wrDone && hitIndex(paddr, `SLXB_IDX_IRQ_MASK)) begin
            irqMask_q <= pwdata[7:0];
         end
      end
   end

   assign irq = |(irqStatus_q & irqMask_q);

endmodule // slxb_crossbar_upper

`default_nettype wire

//--- slxb_crossbar_upper_props.sv
// Port checker of the upper lane crossbar.
`timescale 1ns/1ps
`default_nettype none
`include "slxb_regs.vh"
module slxb_crossbar_upper_props (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [7:0]  physical_serial_input,
   input wire logic [7:0]  laneFifoFull,
   input wire logic [3:0]  logicalLaneOut
);
   wire        done = psel && penable && pready;
   wire  [7:0] pin  = physical_serial_input;
   logic [5:0] s45_q;
   logic [5:0] s67_q;
   // Shadow selectors follow completed writes, as the register file is hidden.
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn) begin
         s45_q <= 6'h2c;
         s67_q <= 6'h3e;
      end else if (done && pwrite) begin
         if (paddr == `SLXB_ADDR_XBAR45) s45_q <= pwdata[5:0];
         if (paddr == `SLXB_ADDR_XBAR67) s67_q <= pwdata[5:0];
      end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   AST_LANE4: assert property ($past(rstn) |-> logicalLaneOut[0] == $past(pin[s45_q[2:0]]))
      else $error("lane 4 source");
   AST_LANE5: assert property ($past(rstn) |-> logicalLaneOut[1] == $past(pin[s45_q[5:3]]))
      else $error("lane 5 source");
   AST_LANE6: assert property ($past(rstn) |-> logicalLaneOut[2] == $past(pin[s67_q[2:0]]))
      else $error("lane 6 source");
   AST_LANE7: assert property ($past(rstn) |-> logicalLaneOut[3] == $past(pin[s67_q[5:3]]))
      else $error("lane 7 source");
   AST_RD45: assert property (
      done && !pwrite && paddr == `SLXB_ADDR_XBAR45 |-> prdata == {26'h0, s45_q}) else $error("read 4/5");
   AST_RD67: assert property (
      done && !pwrite && paddr == `SLXB_ADDR_XBAR67 |-> prdata == {26'h0, s67_q}) else $error("read 6/7");
   AST_FULL: assert property (
      done && !pwrite && paddr == `SLXB_ADDR_FULL_STATUS |-> prdata == {24'h0, $past(laneFifoFull, 2)})
      else $error("full status");
endmodule // slxb_crossbar_upper_props
bind slxb_crossbar_upper slxb_crossbar_upper_props slxb_crossbar_upper_props_inst (.core_clk, .rstn, .psel,
   .penable, .pwrite, .pready, .paddr, .pwdata, .prdata, .physical_serial_input, .laneFifoFull, .logicalLaneOut);
`default_nettype wire

//--- slxb_lane_source.sv
// Behavioural lane transmitter with its receive buffer flags.
`timescale 1ns/1ps
`default_nettype none
module slxb_lane_source (
   input  wire logic       core_clk,
   input  wire logic [7:0] txBits,
   input  wire logic [7:0] fullCmd,
   output var  logic [7:0] serialOut = 8'h00,
   output var  logic [7:0] fullOut = 8'h00
);
   // Fresh bits every cycle, so a wrongly routed lane cannot match by luck.
   always @(posedge core_clk) begin
      serialOut <= txBits;
      fullOut   <= fullCmd;
   end
endmodule // slxb_lane_source
`default_nettype wire

//--- slxb_crossbar_upper_bench.sv
// Self-checking bench of the upper lane crossbar.
`timescale 1ns/1ps
`default_nettype none
`include "slxb_regs.vh"
module slxb_crossbar_upper_bench;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rnd = 32'h700e932a;
   logic [7:0]  txBits = 8'h00;
   logic [7:0]  fullCmd = 8'h00;
   logic [2:0]  sel;
   logic [33:0] expQ[$];
   wire  [31:0] prdata;
   wire  [7:0]  serialIn;
   wire  [7:0]  fullIn;
   wire         pready;
   wire         pslverr;
   wire         irq;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   initial forever #50 core_clk = ~core_clk;
   slxb_lane_source slxb_lane_source_inst (.core_clk, .txBits, .fullCmd, .serialOut(serialIn), .fullOut(fullIn));
   slxb_crossbar_upper slxb_crossbar_upper_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .physical_serial_input(serialIn), .laneFifoFull(fullIn), .logicalLaneOut(),
      .irq);
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk_rd(input logic [33:0] e, input logic err, input logic [31:0] got);
      if (e[33]) begin
         tests_run++;
         if ({err, got} !== e[32:0]) begin
            bad_count++;
            $display("[ERR] %0t read want %h got %h", $time, e[32:0], {err, got});
         end
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t irq is %b", $time, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      if (!w) expQ.push_back(e);
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {2'h2, d});
   endtask
   task automatic irq_after(input logic [7:0] f, input logic exp);
      @(posedge core_clk);
      fullCmd <= f;
      repeat (4) @(negedge core_clk);
      chk_bit(irq, exp);
   endtask
   ////////////////////////////////////////////////////////////
   always @(negedge core_clk)
      if (psel && penable && pready === 1'b1 && !pwrite) chk_rd(expQ.pop_front(), pslverr, prdata);
   always @(posedge core_clk) begin
      rnd    <= xs(rnd);
      txBits <= rnd[7:0];
      cyc    <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      rd(`SLXB_ADDR_XBAR45, 32'h2c);
      rd(`SLXB_ADDR_XBAR67, 32'h3e);
      rd(`SLXB_ADDR_FULL_STATUS, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         sel = i[2:0];
         wr(`SLXB_ADDR_XBAR45, {rnd[31:6], sel, 3'h7 - sel});
         wr(`SLXB_ADDR_XBAR67, {rnd[25:0], 3'h7 - sel, sel});
         rd(`SLXB_ADDR_XBAR45, {26'h0, sel, 3'h7 - sel});
         rd(`SLXB_ADDR_XBAR67, {26'h0, 3'h7 - sel, sel});
      end
      $display("selector test done");
      repeat (4) begin
         fullCmd <= rnd[15:8];
         wr(`SLXB_ADDR_FULL_STATUS, 32'hff);
         rd(`SLXB_ADDR_FULL_STATUS, {24'h0, fullCmd});
      end
      $display("status test done");
      // Random status traffic leaves sticky bits behind; clear them before the
      // interrupt checks so each expectation depends only on its own event.
      apb(1'b0, `SLXB_ADDR_IRQ_STATUS, 32'h0, 34'h0);
      wr(`SLXB_ADDR_IRQ_MASK, 32'h04);
      irq_after(8'h00, 1'b0);
      irq_after(8'h0c, 1'b1);
      rd(`SLXB_ADDR_IRQ_STATUS, 32'h0c);
      irq_after(8'h1c, 1'b0);
      rd(`SLXB_ADDR_IRQ_STATUS, 32'h10);
      apb(1'b0, 12'hffc, 32'h0, {2'h3, 32'h0});
      apb(1'b0, 12'hc29, 32'h0, {2'h3, 32'h0});
      $display("irq and error test done");
      wrap_up();
   end
endmodule // slxb_crossbar_upper_bench
`default_nettype wire
